// ### inc/mcfi_defines.svh
// Constants of the motion command frame interpreter
// Behaviour
// - Command body: opcode, type, selector, four value bytes
// - Serial frames add address and checksum: nine bytes
// - Serial order: address, opcode, type, selector, value MSB-first, checksum
// - Command checksum is 8-bit sum including address
// - Reply status codes 100,101,1..6 as defined
// - Exactly one reply per received command frame; serial frames for another module address get none
// - Reply order: reply address, module address, status, opcode, value, checksum
// - Reply checksum is 8-bit sum of other bytes
// - CAN commands carry no address or checksum bytes
// - CAN replies carry no reply address or checksum
// - Opcodes 1-4: rotate right, left, halt, move
// - Opcodes 5,6,9,10,11,12: parameter set, get, store, restore
// - Opcodes 13,14,15: reference search, output, input
// - Opcodes 19-24: arithmetic, compare, jumps, call, return
// - Opcodes 25,26,27: interrupt enable, disable, wait
// - Downloaded program stored, then executed locally
// - Never transmit except when answering a command
// - Reply only after requested action has finished
`ifndef MCFI_DEFINES_SVH
`define MCFI_DEFINES_SVH

`define MCFI_OP_ROTATE_RIGHT  8'h01
`define MCFI_OP_ROTATE_LEFT   8'h02
`define MCFI_OP_MOTOR_HALT    8'h03
`define MCFI_OP_MOVE_POS      8'h04
`define MCFI_OP_SET_AXIS      8'h05
`define MCFI_OP_GET_AXIS      8'h06
`define MCFI_OP_SET_GLOBAL    8'h09
`define MCFI_OP_GET_GLOBAL    8'h0a
`define MCFI_OP_STORE_GLOBAL  8'h0b
`define MCFI_OP_RESTORE_GLOB  8'h0c
`define MCFI_OP_REF_SEARCH    8'h0d
`define MCFI_OP_SET_OUTPUT    8'h0e
`define MCFI_OP_GET_INPUT     8'h0f
`define MCFI_OP_ACCU_ARITH    8'h13
`define MCFI_OP_ACCU_COMPARE  8'h14
`define MCFI_OP_COND_JUMP     8'h15
`define MCFI_OP_UNCOND_JUMP   8'h16
`define MCFI_OP_SUB_CALL      8'h17
`define MCFI_OP_SUB_RETURN    8'h18
`define MCFI_OP_INT_ENABLE    8'h19
`define MCFI_OP_INT_DISABLE   8'h1a
`define MCFI_OP_WAIT          8'h1b
`define MCFI_OP_PROG_STOP     8'h1c

`define MCFI_ST_OK            8'h64
`define MCFI_ST_STORED        8'h65
`define MCFI_ST_CKSUM         8'h01
`define MCFI_ST_BAD_OP        8'h02
`define MCFI_ST_BAD_TYPE      8'h03
`define MCFI_ST_BAD_VALUE     8'h04
`define MCFI_ST_LOCKED        8'h05
`define MCFI_ST_UNAVAIL       8'h06

`define MCFI_IDX_ADDR         4'h0
`define MCFI_IDX_OPCODE       4'h1
`define MCFI_IDX_TYPE         4'h2
`define MCFI_IDX_SEL          4'h3
`define MCFI_IDX_VAL3         4'h4
`define MCFI_IDX_VAL2         4'h5
`define MCFI_IDX_VAL1         4'h6
`define MCFI_IDX_VAL0         4'h7
`define MCFI_IDX_CKSUM        4'h8
`define MCFI_IDX_STATUS       4'h2
`define MCFI_IDX_CAN_FIRST    4'h1

`endif

// ### inc/mcfi_pkg.sv
// Types of the motion command frame interpreter
`default_nettype none
package mcfi_pkg;
  typedef logic [7:0] mcfi_byte_t;
  typedef enum logic [2:0] {
    S_RECV, S_CHECK, S_EXEC, S_REPLY_LOAD, S_REPLY, S_FETCH, S_DECODE, S_RUN
  } mcfi_state_e;
endpackage : mcfi_pkg
`default_nettype wire

// ### hw/mcfi_prog_mem.sv
// Program memory holding downloaded command words
`timescale 1ns/1ps
`default_nettype none
module mcfi_prog_mem #(
  parameter int WIDTH = 56,
  parameter int DEPTH = 256,
  parameter int AW    = 8
) (
  // Clock
  input  wire logic             core_clk,
  // Write port
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  // Read port
  input  wire logic             rd_en,
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Registered read so the array maps onto block RAM
  always_ff @(posedge core_clk) begin
    if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule : mcfi_prog_mem
`default_nettype wire

// ### hw/mcfi_interp.sv
// Command frame receiver, checker, dispatcher, replier and program runner
`timescale 1ns/1ps
`default_nettype none
`include "mcfi_defines.svh"
module mcfi_interp
  import mcfi_pkg::*;
#(
  parameter int PROG_DEPTH = 256,
  parameter int PROG_AW    = 8
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // Link configuration
  input  wire logic        link_can,
  input  wire logic [7:0]  module_addr,
  input  wire logic [7:0]  reply_addr,
  // Received bytes
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  output logic             rx_ready,
  // Reply bytes
  output logic             tx_valid,
  output logic [7:0]       tx_data,
  output logic             tx_last,
  input  wire logic        tx_ready,
  // Command execution by the motion core
  output logic             exec_req,
  output logic             exec_from_prog,
  output logic [7:0]       exec_opcode,
  output logic [7:0]       exec_type,
  output logic [7:0]       exec_sel,
  output logic [31:0]      exec_value,
  input  wire logic        exec_done,
  input  wire logic [7:0]  exec_status,
  input  wire logic [31:0] exec_result,
  input  wire logic        exec_cond,
  // Standalone program control
  input  wire logic        prog_load,
  input  wire logic        prog_start,
  output logic             prog_running
);
  mcfi_state_e         state_r;
  logic [3:0]          rx_idx_r;
  logic [3:0]          tx_idx_r;
  logic [7:0]          addr_r;
  logic [7:0]          op_r;
  logic [7:0]          type_r;
  logic [7:0]          sel_r;
  logic [31:0]         val_r;
  logic [7:0]          cks_r;
  logic [7:0]          rx_sum_r;
  logic [7:0]          tx_sum_r;
  logic [7:0]          tx_sum_nxt;
  logic [7:0]          status_r;
  logic [31:0]         result_r;
  logic [7:0]          tx_data_r;
  logic [PROG_AW-1:0]  pc_r;
  logic [PROG_AW-1:0]  ret_r;
  logic [PROG_AW-1:0]  load_ptr_r;
  logic                running_r;
  logic                link_can_r;
  logic [55:0]         mem_rdata;
  logic [3:0]          first_idx;
  logic [3:0]          last_idx;
  logic                rx_take;
  logic                tx_take;
  logic                addr_ok;
  logic                sum_ok;

  function automatic logic known_op(input logic [7:0] op);
    case (op)
      `MCFI_OP_ROTATE_RIGHT, `MCFI_OP_ROTATE_LEFT, `MCFI_OP_MOTOR_HALT,
      `MCFI_OP_MOVE_POS: known_op = 1'b1;
      `MCFI_OP_SET_AXIS, `MCFI_OP_GET_AXIS, `MCFI_OP_SET_GLOBAL, `MCFI_OP_GET_GLOBAL,
      `MCFI_OP_STORE_GLOBAL, `MCFI_OP_RESTORE_GLOB: known_op = 1'b1;
      `MCFI_OP_REF_SEARCH, `MCFI_OP_SET_OUTPUT, `MCFI_OP_GET_INPUT: known_op = 1'b1;
      `MCFI_OP_ACCU_ARITH, `MCFI_OP_ACCU_COMPARE, `MCFI_OP_COND_JUMP,
      `MCFI_OP_UNCOND_JUMP, `MCFI_OP_SUB_CALL, `MCFI_OP_SUB_RETURN: known_op = 1'b1;
      `MCFI_OP_INT_ENABLE, `MCFI_OP_INT_DISABLE, `MCFI_OP_WAIT,
      `MCFI_OP_PROG_STOP: known_op = 1'b1;
      default: known_op = 1'b0;
    endcase
  endfunction : known_op

  // Byte of the reply at a given position; the checksum slot returns the sum so far
  function automatic logic [7:0] reply_byte(input logic [3:0] idx, input logic [7:0] sum);
    case (idx)
      `MCFI_IDX_ADDR:   reply_byte = reply_addr;
      `MCFI_IDX_OPCODE: reply_byte = module_addr;
      `MCFI_IDX_STATUS: reply_byte = status_r;
      `MCFI_IDX_SEL:    reply_byte = op_r;
      `MCFI_IDX_VAL3:   reply_byte = result_r[31:24];
      `MCFI_IDX_VAL2:   reply_byte = result_r[23:16];
      `MCFI_IDX_VAL1:   reply_byte = result_r[15:8];
      `MCFI_IDX_VAL0:   reply_byte = result_r[7:0];
      default:          reply_byte = sum;
    endcase
  endfunction : reply_byte

  assign first_idx  = link_can ? `MCFI_IDX_CAN_FIRST : `MCFI_IDX_ADDR;
  assign last_idx   = link_can ? `MCFI_IDX_VAL0 : `MCFI_IDX_CKSUM;
  assign rx_ready   = (state_r == S_RECV);
  assign rx_take    = rx_valid && rx_ready;
  assign tx_valid   = (state_r == S_REPLY);
  assign tx_take    = tx_valid && tx_ready;
  assign tx_data    = tx_data_r;
  assign tx_last    = tx_valid && (tx_idx_r == last_idx);
  assign tx_sum_nxt = tx_sum_r + tx_data_r;
  assign addr_ok    = link_can || (addr_r == module_addr);
  assign sum_ok     = link_can || (rx_sum_r == cks_r);
  assign exec_req   = (state_r == S_EXEC) || (state_r == S_RUN);
  assign exec_from_prog = (state_r == S_RUN);
  assign exec_opcode  = op_r;
  assign exec_type    = type_r;
  assign exec_sel     = sel_r;
  assign exec_value   = val_r;
  assign prog_running = running_r;

  // Main sequence
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state_r <= S_RECV;
    end else begin
      case (state_r)
        S_RECV: begin
          if (rx_take && rx_idx_r == last_idx) begin
            state_r <= S_CHECK;
          end else if (!rx_valid && running_r && rx_idx_r == first_idx) begin
            state_r <= S_FETCH;
          end
        end
        S_CHECK: begin
          if (!addr_ok) begin
            state_r <= S_RECV;
          end else if (!sum_ok || !known_op(op_r) || prog_load) begin
            state_r <= S_REPLY_LOAD;
          end else begin
            state_r <= S_EXEC;
          end
        end
        S_EXEC: begin
          if (exec_done) begin
            state_r <= S_REPLY_LOAD;
          end
        end
        S_REPLY_LOAD: state_r <= S_REPLY;
        S_REPLY: begin
          if (tx_take && tx_idx_r == last_idx) begin
            state_r <= S_RECV;
          end
        end
        S_FETCH: state_r <= S_DECODE;
        S_DECODE: begin
          case (mem_rdata[55:48])
            `MCFI_OP_COND_JUMP, `MCFI_OP_UNCOND_JUMP, `MCFI_OP_SUB_CALL,
            `MCFI_OP_SUB_RETURN, `MCFI_OP_PROG_STOP: state_r <= S_RECV;
            default: state_r <= known_op(mem_rdata[55:48]) ? S_RUN : S_RECV;
          endcase
        end
        S_RUN: begin
          if (exec_done) begin
            state_r <= S_RECV;
          end
        end
        default: state_r <= S_RECV;
      endcase
    end
  end

  // Command fields, filled by the link or by the program fetch
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      rx_idx_r <= `MCFI_IDX_ADDR;
      addr_r   <= 8'h00;
      op_r     <= 8'h00;
      type_r   <= 8'h00;
      sel_r    <= 8'h00;
      val_r    <= 32'h0000_0000;
      cks_r    <= 8'h00;
      rx_sum_r <= 8'h00;
    end else if (rx_take) begin
      rx_idx_r <= (rx_idx_r == last_idx) ? first_idx : rx_idx_r + 4'h1;
      if (rx_idx_r != `MCFI_IDX_CKSUM) begin
        rx_sum_r <= (rx_idx_r == first_idx) ? rx_data : rx_sum_r + rx_data;
      end
      case (rx_idx_r)
        `MCFI_IDX_ADDR:   addr_r        <= rx_data;
        `MCFI_IDX_OPCODE: op_r          <= rx_data;
        `MCFI_IDX_TYPE:   type_r        <= rx_data;
        `MCFI_IDX_SEL:    sel_r         <= rx_data;
        `MCFI_IDX_VAL3:   val_r[31:24]  <= rx_data;
        `MCFI_IDX_VAL2:   val_r[23:16]  <= rx_data;
        `MCFI_IDX_VAL1:   val_r[15:8]   <= rx_data;
        `MCFI_IDX_VAL0:   val_r[7:0]    <= rx_data;
        default:          cks_r         <= rx_data;
      endcase
    end else begin
      if (rx_idx_r < first_idx || link_can != link_can_r) begin
        rx_idx_r <= first_idx;
      end
      if (state_r == S_DECODE) begin
        {op_r, type_r, sel_r, val_r} <= mem_rdata;
      end
    end
  end

  // Mode of the last cycle; an idle index left by the other framing is ambiguous otherwise
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      link_can_r <= 1'b0;
    end else begin
      link_can_r <= link_can;
    end
  end

  // Status and result of the reply
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      status_r <= `MCFI_ST_OK;
      result_r <= 32'h0000_0000;
    end else if (state_r == S_CHECK) begin
      result_r <= val_r;
      if (!sum_ok) begin
        status_r <= `MCFI_ST_CKSUM;
      end else if (!known_op(op_r)) begin
        status_r <= `MCFI_ST_BAD_OP;
      end else if (prog_load) begin
        status_r <= `MCFI_ST_STORED;
      end else begin
        status_r <= `MCFI_ST_OK;
      end
    end else if (state_r == S_EXEC && exec_done) begin
      status_r <= exec_status;
      result_r <= exec_result;
    end
  end

  // Reply serialiser; data always leaves from a flop
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      tx_idx_r  <= `MCFI_IDX_ADDR;
      tx_data_r <= 8'h00;
      tx_sum_r  <= 8'h00;
    end else if (state_r == S_REPLY_LOAD) begin
      tx_idx_r  <= first_idx;
      tx_sum_r  <= 8'h00;
      tx_data_r <= reply_byte(first_idx, 8'h00);
    end else if (tx_take && tx_idx_r != last_idx) begin
      tx_idx_r  <= tx_idx_r + 4'h1;
      tx_sum_r  <= tx_sum_nxt;
      tx_data_r <= reply_byte(tx_idx_r + 4'h1, tx_sum_nxt);
    end
  end

  // Program download pointer; each download session starts at word zero
  always_ff @(posedge core_clk) begin
    if (!rstn || !prog_load) begin
      load_ptr_r <= '0;
    end else if (state_r == S_CHECK && addr_ok && sum_ok && known_op(op_r)) begin
      load_ptr_r <= load_ptr_r + 1'b1;
    end
  end

  // Standalone program counter, one-level return address
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      running_r <= 1'b0;
      pc_r      <= '0;
      ret_r     <= '0;
    end else if (prog_load) begin
      running_r <= 1'b0;
    end else if (prog_start && !running_r) begin
      running_r <= 1'b1;
      pc_r      <= '0;
    end else if (state_r == S_DECODE) begin
      case (mem_rdata[55:48])
        `MCFI_OP_UNCOND_JUMP: pc_r <= mem_rdata[PROG_AW-1:0];
        `MCFI_OP_COND_JUMP:   pc_r <= exec_cond ? mem_rdata[PROG_AW-1:0] : pc_r + 1'b1;
        `MCFI_OP_SUB_CALL: begin
          ret_r <= pc_r + 1'b1;
          pc_r  <= mem_rdata[PROG_AW-1:0];
        end
        `MCFI_OP_SUB_RETURN: pc_r <= ret_r;
        `MCFI_OP_PROG_STOP:  running_r <= 1'b0;
        default: begin
          if (!known_op(mem_rdata[55:48])) begin
            running_r <= 1'b0;
          end
        end
      endcase
    end else if (state_r == S_RUN && exec_done) begin
      pc_r <= pc_r + 1'b1;
    end
  end

  mcfi_prog_mem #(
    .WIDTH (56),
    .DEPTH (PROG_DEPTH),
    .AW    (PROG_AW)
  ) u_prog_mem (
    .core_clk (core_clk),
    .wr_en    (state_r == S_CHECK && prog_load && addr_ok && sum_ok && known_op(op_r)),
    .wr_addr  (load_ptr_r),
    .wr_data  ({op_r, type_r, sel_r, val_r}),
    .rd_en    (state_r == S_FETCH),
    .rd_addr  (pc_r),
    .rd_data  (mem_rdata)
  );

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  a_frame_len_serial: assert property (
    rx_take && !link_can && rx_idx_r == `MCFI_IDX_CKSUM |=> state_r == S_CHECK)
    else $error("serial frame not closed after ninth byte");
  a_frame_len_can: assert property (
    rx_take && link_can && rx_idx_r == `MCFI_IDX_VAL0 |=> state_r == S_CHECK)
    else $error("CAN frame not closed after seventh byte");
  a_cksum_status: assert property (
    state_r == S_CHECK && !link_can && addr_ok && rx_sum_r != cks_r
      |=> status_r == `MCFI_ST_CKSUM ##1 state_r == S_REPLY)
    else $error("bad checksum not answered with status 1");
  a_bad_op_status: assert property (
    state_r == S_CHECK && addr_ok && sum_ok && !known_op(op_r)
      |=> status_r == `MCFI_ST_BAD_OP && state_r == S_REPLY_LOAD)
    else $error("unknown opcode not answered with status 2");
  a_store_status: assert property (
    state_r == S_CHECK && addr_ok && sum_ok && known_op(op_r) && prog_load
      |=> status_r == `MCFI_ST_STORED && !exec_req)
    else $error("download not answered with status 101");
  a_addr_discard: assert property (
    state_r == S_CHECK && !addr_ok |=> state_r == S_RECV ##1 !tx_valid)
    else $error("frame for another address answered");
  a_reply_after_exec: assert property (
    state_r == S_EXEC && exec_done |=> state_r == S_REPLY_LOAD ##1 tx_valid)
    else $error("reply not started after execution finished");
  a_no_tx_in_exec: assert property (tx_valid |-> !exec_req && !rx_ready)
    else $error("transmit while not answering");
  a_opcode_echo: assert property (
    tx_take && tx_idx_r == `MCFI_IDX_STATUS |=> tx_data == op_r)
    else $error("opcode not echoed after status byte");
  a_msb_first: assert property (
    tx_take && tx_idx_r == `MCFI_IDX_SEL |=> tx_data == result_r[31:24])
    else $error("result not sent most significant byte first");
  a_reply_cksum: assert property (
    tx_valid && !link_can && tx_idx_r == `MCFI_IDX_CKSUM
      |-> tx_data == tx_sum_r && tx_last)
    else $error("reply checksum mismatch");
  a_can_reply: assert property (
    tx_valid && link_can |-> tx_idx_r >= `MCFI_IDX_CAN_FIRST && tx_idx_r <= `MCFI_IDX_VAL0)
    else $error("CAN reply carries address or checksum");
  a_one_reply: assert property (tx_take && tx_last |=> !tx_valid)
    else $error("second reply without new command");

  c_serial_reply: cover property (tx_take && tx_last && !link_can && status_r == `MCFI_ST_OK);
  c_can_reply:    cover property (tx_take && tx_last && link_can);
  c_cksum_err:    cover property (tx_valid && status_r == `MCFI_ST_CKSUM);
  c_prog_step:    cover property (state_r == S_RUN && exec_done);
endmodule : mcfi_interp
`default_nettype wire

// ### tb/mcfi_host_model.sv
// Host bus master and motion core model facing the command interpreter
`timescale 1ns/1ps
`default_nettype none
module mcfi_host_model (
  // Clock
  input  wire logic        core_clk,
  // Byte link
  output logic             rx_valid,
  output logic [7:0]       rx_data,
  input  wire logic        rx_ready,
  input  wire logic        tx_valid,
  input  wire logic [7:0]  tx_data,
  input  wire logic        tx_last,
  output logic             tx_ready,
  // Motion core
  input  wire logic        exec_req,
  input  wire logic        exec_from_prog,
  input  wire logic [7:0]  exec_opcode,
  input  wire logic [7:0]  exec_type,
  input  wire logic [7:0]  exec_sel,
  input  wire logic [31:0] exec_value,
  output logic             exec_done,
  output logic [7:0]       exec_status,
  output logic [31:0]      exec_result
);
  int          lat = 2;
  int          cnt = 0;
  int          n_exec = 0;
  logic [7:0]  core_st = 8'h64;
  logic [55:0] got_cmd = '0;
  logic        got_prog = 1'b0;
  logic [7:0]  rep [9];
  logic        rep_ok;

  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b0;
    exec_done = 1'b0;
  end

  // Status and result carry garbage outside the done cycle
  assign exec_status = exec_done ? core_st : ~core_st;
  assign exec_result = exec_done ? {exec_value[23:0], exec_opcode} : ~exec_value;

  always @(negedge core_clk) begin
    exec_done <= 1'b0;
    if (exec_req === 1'b1 && !exec_done) begin
      if (cnt >= lat) begin
        exec_done <= 1'b1;
        cnt <= 0;
        n_exec <= n_exec + 1;
        got_cmd <= {exec_opcode, exec_type, exec_sel, exec_value};
        got_prog <= exec_from_prog;
      end else begin
        cnt <= cnt + 1;
      end
    end
  end

  task automatic send_frame(input logic can, input logic [7:0] adr, input logic [55:0] body,
                            input logic [7:0] ckx);
    logic [7:0] b [9];
    logic [7:0] ck;
    int         n;
    int         i;
    int         k;
    n = can ? 0 : 1;
    b[0] = adr;
    for (i = 0; i < 7; i++) b[n + i] = body[55 - 8 * i -: 8];
    ck = 8'h00;
    for (i = 0; i < 8; i++) ck = ck + b[i];
    b[8] = ck ^ ckx;
    n = can ? 7 : 9;
    for (i = 0; i < n; i++) begin
      @(negedge core_clk);
      rx_valid = 1'b1;
      rx_data = b[i];
      k = 0;
      while (rx_ready !== 1'b1 && k < 300) begin
        @(negedge core_clk);
        k++;
      end
      @(posedge core_clk);
    end
    // Released line must not keep showing the last byte
    @(negedge core_clk);
    rx_valid = 1'b0;
    rx_data = ~b[n - 1];
  endtask : send_frame

  task automatic get_reply(input int n);
    int i;
    int k;
    rep_ok = 1'b1;
    for (i = 0; i < n; i++) begin
      k = 0;
      @(negedge core_clk);
      tx_ready = (i != 2);
      // Sampled at the falling edge, where the byte taken by the next rising edge stands
      while (!(tx_valid === 1'b1 && tx_ready) && k < 300) begin
        k++;
        @(negedge core_clk);
        tx_ready = 1'b1;
      end
      rep[i] = tx_data;
      if (tx_last !== (i == n - 1)) rep_ok = 1'b0;
      @(posedge core_clk);
    end
    @(negedge core_clk);
    tx_ready = 1'b0;
  endtask : get_reply
endmodule : mcfi_host_model
`default_nettype wire

// ### tb/tb.sv
// Self-checking bench of the motion command frame interpreter
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp, msg) begin samples_checked++; if ((got) !== (exp)) begin err_total++; \
  $display("mismatch at %0t: %s", $time, msg); end end
module tb;
  logic        core_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        link_can = 1'b0;
  logic        exec_cond = 1'b0;
  logic        prog_load = 1'b0;
  logic        prog_start = 1'b0;
  logic [7:0]  module_addr = 8'h2a;
  logic [7:0]  reply_addr = 8'h02;
  wire logic   rx_valid, rx_ready, tx_valid, tx_last, tx_ready, exec_req, exec_from_prog;
  wire logic   exec_done, prog_running;
  wire logic [7:0]  rx_data, tx_data, exec_opcode, exec_type, exec_sel, exec_status;
  wire logic [31:0] exec_value, exec_result;
  int          err_total = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  logic        tx_seen = 1'b0;

  mcfi_interp dut (.core_clk, .rstn, .link_can, .module_addr, .reply_addr, .rx_valid, .rx_data,
    .rx_ready, .tx_valid, .tx_data, .tx_last, .tx_ready, .exec_req, .exec_from_prog, .exec_opcode,
    .exec_type, .exec_sel, .exec_value, .exec_done, .exec_status, .exec_result, .exec_cond,
    .prog_load, .prog_start, .prog_running);
  mcfi_host_model host (.core_clk, .rx_valid, .rx_data, .rx_ready, .tx_valid, .tx_data, .tx_last,
    .tx_ready, .exec_req, .exec_from_prog, .exec_opcode, .exec_type, .exec_sel, .exec_value,
    .exec_done, .exec_status, .exec_result);

  initial forever #2 core_clk = ~core_clk;

  // Whole run needs well under 20000 cycles
  always @(posedge core_clk) begin
    cyc++;
    if (tx_valid === 1'b1) tx_seen = 1'b1;
    if (cyc == 20000) begin
      err_total++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict

  // Result bytes are unspecified for some statuses, so full_cmp can skip them
  task automatic run_cmd(input logic can, input logic [7:0] adr, input logic [55:0] body,
                         input logic [7:0] ckx, input logic [7:0] st, input logic [31:0] res,
                         input logic full_cmp);
    logic [7:0] ex [9];
    logic [7:0] ck;
    int         n;
    int         i;
    n = can ? 7 : 9;
    host.send_frame(can, adr, body, ckx);
    host.get_reply(n);
    ex[0] = reply_addr;
    ex[1] = module_addr;
    ex[2] = st;
    ex[3] = body[55:48];
    for (i = 0; i < 4; i++) ex[4 + i] = res[31 - 8 * i -: 8];
    ck = 8'h00;
    for (i = 0; i < 8; i++) ck = ck + ex[i];
    ex[8] = ck;
    if (can) for (i = 0; i < 7; i++) ex[i] = ex[i + 1];
    for (i = 0; i < n; i++) if (full_cmp || i < (can ? 3 : 4)) `CHK(host.rep[i], ex[i], "reply byte")
    ck = 8'h00;
    for (i = 0; i < 8; i++) ck = ck + host.rep[i];
    if (!can) `CHK(host.rep[8], ck, "reply checksum")
    `CHK(host.rep_ok, 1'b1, "last marker")
  endtask : run_cmd

  task automatic t_status();
    logic [7:0]  sts [5] = '{8'h64, 8'h03, 8'h04, 8'h05, 8'h06};
    logic [55:0] body = {8'h04, 8'h01, 8'h00, 32'h8001_ff7e};
    int          i;
    for (i = 0; i < 5; i++) begin
      host.core_st = sts[i];
      host.lat = 3 * i;
      run_cmd(1'b0, module_addr, body, 8'h00, sts[i], {body[23:0], 8'h04}, 1'b1);
      `CHK(host.got_cmd, body, "command fields")
      `CHK(host.got_prog, 1'b0, "direct source")
    end
    host.core_st = 8'h64;
    $display("test status done");
  endtask : t_status

  task automatic t_errors();
    int n0;
    n0 = host.n_exec;
    run_cmd(1'b0, module_addr, {8'h01, 16'h0, 32'h1234_5678}, 8'h01, 8'h01, '0, 1'b0);
    run_cmd(1'b0, module_addr, {8'h07, 16'h0, 32'h00a5_5a01}, 8'h00, 8'h02, 32'h00a5_5a01, 1'b1);
    run_cmd(1'b0, module_addr, {8'h10, 16'h0, 32'hff00_0011}, 8'h00, 8'h02, 32'hff00_0011, 1'b1);
    `CHK(host.n_exec, n0, "no execution on error")
    $display("test errors done");
  endtask : t_errors

  task automatic t_addr();
    int n0;
    n0 = host.n_exec;
    tx_seen = 1'b0;
    host.send_frame(1'b0, 8'h2b, {8'h03, 16'h0, 32'h0}, 8'h00);
    repeat (40) @(negedge core_clk);
    `CHK(tx_seen, 1'b0, "reply to foreign address")
    `CHK(host.n_exec, n0, "foreign frame executed")
    run_cmd(1'b0, module_addr, {8'h03, 16'h0, 32'h0}, 8'h00, 8'h64, 32'h0000_0003, 1'b1);
    $display("test address done");
  endtask : t_addr

  task automatic t_can();
    @(negedge core_clk);
    link_can = 1'b1;
    run_cmd(1'b1, 8'h00, {8'h06, 8'h04, 8'h00, 32'h7f00_0102}, 8'h00, 8'h64, 32'h0001_0206,
            1'b1);
    `CHK(host.got_cmd[55:48], 8'h06, "frame opcode")
    @(negedge core_clk);
    link_can = 1'b0;
    $display("test can done");
  endtask : t_can

  task automatic t_opcodes();
    logic [7:0] ops [23] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h09, 8'h0a, 8'h0b,
                             8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17,
                             8'h18, 8'h19, 8'h1a, 8'h1b, 8'h1c};
    int         i;
    host.lat = 0;
    for (i = 0; i < 23; i++) begin
      run_cmd(1'b0, module_addr, {ops[i], 8'h02, 8'h01, 32'h0000_0040}, 8'h00, 8'h64,
              {24'h000040, ops[i]}, 1'b1);
      `CHK(host.got_cmd[55:48], ops[i], "dispatched opcode")
    end
    $display("test opcodes done");
  endtask : t_opcodes

  task automatic t_program();
    logic [55:0] body = {8'h01, 8'h00, 8'h00, 32'h0000_c350};
    int          n0;
    int          k;
    n0 = host.n_exec;
    @(negedge core_clk);
    prog_load = 1'b1;
    run_cmd(1'b0, module_addr, body, 8'h00, 8'h65, '0, 1'b0);
    run_cmd(1'b0, module_addr, {8'h1c, 48'h0}, 8'h00, 8'h65, '0, 1'b0);
    `CHK(host.n_exec, n0, "stored word executed early")
    @(negedge core_clk);
    prog_load = 1'b0;
    tx_seen = 1'b0;
    @(negedge core_clk);
    prog_start = 1'b1;
    @(negedge core_clk);
    prog_start = 1'b0;
    k = 0;
    while (host.n_exec == n0 && k < 200) begin
      @(negedge core_clk);
      k++;
    end
    `CHK(host.got_cmd, body, "stored word")
    `CHK(host.got_prog, 1'b1, "program source")
    k = 0;
    while (prog_running !== 1'b0 && k < 200) begin
      @(negedge core_clk);
      k++;
    end
    `CHK(prog_running, 1'b0, "program stop")
    `CHK(tx_seen, 1'b0, "reply from program")
    $display("test program done");
  endtask : t_program

  initial begin
    repeat (16) @(negedge core_clk);
    rstn = 1'b1;
    `CHK(rx_ready, 1'b1, "reset ready")
    `CHK(tx_valid, 1'b0, "reset reply")
    `CHK(exec_req, 1'b0, "reset request")
    `CHK(prog_running, 1'b0, "reset program")
    t_status();
    t_errors();
    t_addr();
    t_can();
    t_opcodes();
    t_program();
    print_verdict();
  end
endmodule : tb
`default_nettype wire
